// ---- hdl/gpa_port.v ----
// Eight-bit bidirectional port with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "gpa_consts.vh"

module gpa_port #(
    parameter WIDTH = 8
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             hsel,
    input  wire [31:0]      haddr,
    input  wire [1:0]       htrans,
    input  wire             hwrite,
    input  wire [2:0]       hsize,
    input  wire [31:0]      hwdata,
    input  wire             hready,
    output reg  [31:0]      hrdata,
    output reg              hreadyout,
    output reg              hresp,
    input  wire [WIDTH-1:0] pad_in,
    output wire [WIDTH-1:0] pad_out_q,
    output wire [WIDTH-1:0] pad_oe_n_q,
    output reg              timer_ext_clock_in_q,
    output reg  [WIDTH-1:0] analog_sel_q,
    output reg              comparator_ref_out_q,
    output reg  [1:0]       osc_mode_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    function is_reg;
        input [`GPA_ADDR_BITS-1:0] addr;
        input [`GPA_ADDR_BITS-1:0] ofs;
        begin
            is_reg = (addr == ofs);
        end
    endfunction

    function [WIDTH-1:0] keep_port_bits;
        input [WIDTH-1:0] val;
        input             six_port;
        input             seven_port;
        begin
            keep_port_bits = val;
            if (!six_port) begin
                keep_port_bits[`GPA_PIN_SIX]   = 1'b0;
            end
            if (!seven_port) begin
                keep_port_bits[`GPA_PIN_SEVEN] = 1'b0;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [WIDTH-1:0] latch_q;
    reg  [WIDTH-1:0] latch_d;
    reg  [WIDTH-1:0] dir_q;
    reg  [WIDTH-1:0] dir_d;
    reg  [WIDTH-1:0] analog_sel_d;
    reg              ref_out_d;
    reg  [1:0]       osc_mode_d;

    reg              wr_pend_q;
    reg  [`GPA_ADDR_BITS-1:0] wr_addr_q;

    reg  [31:0]      rdata_d;
    reg  [`GPA_ICLK_DIV_BITS-1:0] iclk_cnt_q;

    wire [WIDTH-1:0] level_w;
    wire             addr_phase;
    wire [`GPA_ADDR_BITS-1:0] addr_lo;
    wire             six_seven_port;
    wire             clkout_on;
    wire             osc_owns_seven;
    wire             six_port_d;
    wire             seven_port_d;

    reg  [WIDTH-1:0] gpio_en;
    reg  [WIDTH-1:0] alt_drive;
    reg  [WIDTH-1:0] alt_hiz;
    reg  [WIDTH-1:0] alt_val;
    reg  [WIDTH-1:0] drive_mask;

    assign addr_phase     = hsel && hready && (htrans == `GPA_HTRANS_NONSEQ);
    assign addr_lo        = haddr[`GPA_ADDR_BITS-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator mode decode for pins six and seven

    assign six_seven_port = (osc_mode_q == `GPA_OSC_BOTH_PORT);
    assign clkout_on      = (osc_mode_q == `GPA_OSC_CLKOUT_SIX);
    assign osc_owns_seven = !six_seven_port && !clkout_on;

    // Port ownership of pins six and seven under the next oscillator mode
    assign six_port_d     = (osc_mode_d == `GPA_OSC_BOTH_PORT);
    assign seven_port_d   = six_port_d || (osc_mode_d == `GPA_OSC_CLKOUT_SIX);

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin ownership

    always @* begin
        gpio_en   = {WIDTH{1'b1}};
        alt_drive = {WIDTH{1'b0}};
        alt_hiz   = {WIDTH{1'b0}};
        alt_val   = {WIDTH{1'b0}};
        if (!six_seven_port) begin
            gpio_en[`GPA_PIN_SIX]   = 1'b0;
            alt_hiz[`GPA_PIN_SIX]   = 1'b1;
        end
        if (clkout_on) begin
            alt_hiz[`GPA_PIN_SIX]   = 1'b0;
            alt_drive[`GPA_PIN_SIX] = 1'b1;
            alt_val[`GPA_PIN_SIX]   = iclk_cnt_q[`GPA_ICLK_DIV_BITS-1];
            gpio_en[`GPA_PIN_SEVEN] = 1'b1;
        end else if (osc_owns_seven) begin
            gpio_en[`GPA_PIN_SEVEN] = 1'b0;
            alt_hiz[`GPA_PIN_SEVEN] = 1'b1;
        end
        if (comparator_ref_out_q) begin
            gpio_en[`GPA_PIN_REF_OUT] = 1'b0;
            alt_hiz[`GPA_PIN_REF_OUT] = 1'b1;
        end
    end

    always @* begin
        drive_mask = ~pad_oe_n_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin cells

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
            gpa_pin_cell u_cell (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .dir_in     (dir_q[gi]),
                .latch_val  (latch_q[gi]),
                .pad_in     (pad_in[gi]),
                .gpio_en    (gpio_en[gi]),
                .analog_sel (analog_sel_q[gi]),
                .alt_drive  (alt_drive[gi]),
                .alt_val    (alt_val[gi]),
                .alt_hiz    (alt_hiz[gi]),
                .pad_out_q  (pad_out_q[gi]),
                .pad_oe_n_q (pad_oe_n_q[gi]),
                .level_q    (level_w[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Instruction clock divider and timer clock tap

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            iclk_cnt_q           <= {`GPA_ICLK_DIV_BITS{1'b0}};
            timer_ext_clock_in_q <= 1'b0;
        end else begin
            iclk_cnt_q           <= iclk_cnt_q + 1'b1;
            timer_ext_clock_in_q <= pad_in[`GPA_PIN_TIMER_CLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path, applied in the data phase

    always @* begin
        latch_d      = latch_q;
        dir_d        = dir_q;
        analog_sel_d = analog_sel_q;
        ref_out_d    = comparator_ref_out_q;
        osc_mode_d   = osc_mode_q;
        if (wr_pend_q) begin
            if (is_reg(wr_addr_q, `GPA_OFS_PIN_LEVELS)) begin
                latch_d = hwdata[WIDTH-1:0];
            end else if (is_reg(wr_addr_q, `GPA_OFS_OUTPUT_LATCH)) begin
                latch_d = hwdata[WIDTH-1:0];
            end else if (is_reg(wr_addr_q, `GPA_OFS_DIRECTION)) begin
                dir_d = hwdata[WIDTH-1:0];
            end else if (is_reg(wr_addr_q, `GPA_OFS_ALT_CONFIG)) begin
                analog_sel_d = hwdata[`GPA_ALT_ANALOG_MSB:`GPA_ALT_ANALOG_LSB]
                               & `GPA_ANALOG_CAPABLE;
                ref_out_d    = hwdata[`GPA_ALT_REF_OUT_BIT];
                osc_mode_d   = hwdata[`GPA_ALT_OSC_MSB:`GPA_ALT_OSC_LSB];
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_q              <= `GPA_RST_OUTPUT_LATCH;
            dir_q                <= `GPA_RST_DIRECTION;
            analog_sel_q         <= `GPA_RST_ANALOG_SEL;
            comparator_ref_out_q <= `GPA_RST_REF_OUT_EN;
            osc_mode_q           <= `GPA_RST_OSC_MODE;
        end else begin
            latch_q              <= latch_d;
            dir_q                <= dir_d;
            analog_sel_q         <= analog_sel_d;
            comparator_ref_out_q <= ref_out_d;
            osc_mode_q           <= osc_mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path, built from next-state values for the latch, direction and alternate
    // config registers so a read right after a write sees the new contents

    always @* begin
        rdata_d = 32'h0000_0000;
        if (is_reg(addr_lo, `GPA_OFS_PIN_LEVELS)) begin
            rdata_d[WIDTH-1:0] = level_w;
        end else if (is_reg(addr_lo, `GPA_OFS_OUTPUT_LATCH)) begin
            rdata_d[WIDTH-1:0] = keep_port_bits(latch_d, six_port_d, seven_port_d);
        end else if (is_reg(addr_lo, `GPA_OFS_DIRECTION)) begin
            rdata_d[WIDTH-1:0] = keep_port_bits(dir_d, six_port_d, seven_port_d);
        end else if (is_reg(addr_lo, `GPA_OFS_ALT_CONFIG)) begin
            rdata_d[`GPA_ALT_ANALOG_MSB:`GPA_ALT_ANALOG_LSB] = analog_sel_d;
            rdata_d[`GPA_ALT_REF_OUT_BIT]                   = ref_out_d;
            rdata_d[`GPA_ALT_OSC_MSB:`GPA_ALT_OSC_LSB]      = osc_mode_d;
        end else if (is_reg(addr_lo, `GPA_OFS_OWNER_STATUS)) begin
            rdata_d[`GPA_OWN_GPIO_LSB+WIDTH-1:`GPA_OWN_GPIO_LSB]     = gpio_en & ~analog_sel_q;
            rdata_d[`GPA_OWN_ANALOG_LSB+WIDTH-1:`GPA_OWN_ANALOG_LSB] = analog_sel_q;
            rdata_d[`GPA_OWN_DRIVE_LSB+WIDTH-1:`GPA_OWN_DRIVE_LSB]   = drive_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= {`GPA_ADDR_BITS{1'b0}};
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wr_pend_q <= addr_phase && hwrite;
                wr_addr_q <= addr_lo;
                if (addr_phase && !hwrite) begin
                    hrdata <= rdata_d;
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- hdl/gpa_consts.vh ----
// Constants for the eight-bit general purpose port block
`ifndef GPA_CONSTS_VH
`define GPA_CONSTS_VH

// Register byte offsets
`define GPA_OFS_PIN_LEVELS      8'h00
`define GPA_OFS_OUTPUT_LATCH    8'h04
`define GPA_OFS_DIRECTION       8'h08
`define GPA_OFS_ALT_CONFIG      8'h0C
`define GPA_OFS_OWNER_STATUS    8'h10

// Decoded address width
`define GPA_ADDR_BITS           8

// Reset values
`define GPA_RST_OUTPUT_LATCH    8'h00
`define GPA_RST_DIRECTION       8'hFF
`define GPA_RST_ANALOG_SEL      8'h2F
`define GPA_RST_REF_OUT_EN      1'b0
`define GPA_RST_OSC_MODE        2'h0

// Pins that may be analog converter inputs
`define GPA_ANALOG_CAPABLE      8'h2F

// Alternate configuration register fields
`define GPA_ALT_ANALOG_LSB      0
`define GPA_ALT_ANALOG_MSB      7
`define GPA_ALT_REF_OUT_BIT     8
`define GPA_ALT_OSC_LSB         9
`define GPA_ALT_OSC_MSB         10

// Owner status register fields
`define GPA_OWN_GPIO_LSB        0
`define GPA_OWN_ANALOG_LSB      8
`define GPA_OWN_DRIVE_LSB       16

// Oscillator pin modes for pins six and seven
`define GPA_OSC_BOTH_PORT       2'h0
`define GPA_OSC_CLKOUT_SIX      2'h1
`define GPA_OSC_BOTH_OSC        2'h2

// Pin positions
`define GPA_PIN_REF_OUT         0
`define GPA_PIN_TIMER_CLK       4
`define GPA_PIN_CHANNEL_FOUR    5
`define GPA_PIN_SIX             6
`define GPA_PIN_SEVEN           7

// Instruction clock divider: hclk divided by four
`define GPA_ICLK_DIV_BITS       2

// AHB-Lite transfer type
`define GPA_HTRANS_NONSEQ       2'h2

`endif

// ---- hdl/gpa_pin_cell.v ----
// One port pin: driver control and digital read path
`timescale 1ns/1ps
`default_nettype none

module gpa_pin_cell (
    input  wire hclk,
    input  wire hresetn,
    input  wire dir_in,
    input  wire latch_val,
    input  wire pad_in,
    input  wire gpio_en,
    input  wire analog_sel,
    input  wire alt_drive,
    input  wire alt_val,
    input  wire alt_hiz,
    output reg  pad_out_q,
    output reg  pad_oe_n_q,
    output reg  level_q
);

    reg pad_out_d;
    reg pad_oe_n_d;
    reg level_d;

    ////////////////////////////////////////////////////////////////////////////
    // Driver and read selection
    always @* begin
        pad_out_d  = latch_val;
        pad_oe_n_d = dir_in;
        if (alt_drive) begin
            pad_out_d  = alt_val;
            pad_oe_n_d = 1'b0;
        end else if (alt_hiz) begin
            pad_out_d  = 1'b0;
            pad_oe_n_d = 1'b1;
        end
        level_d = 1'b0;
        if (gpio_en && !analog_sel && !alt_drive && !alt_hiz) begin
            level_d = pad_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output flops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out_q  <= 1'b0;
            pad_oe_n_q <= 1'b1;
            level_q    <= 1'b0;
        end else begin
            pad_out_q  <= pad_out_d;
            pad_oe_n_q <= pad_oe_n_d;
            level_q    <= level_d;
        end
    end

endmodule

`default_nettype wire

// ---- sim/gpa_board.sv ----
// Board model: what the port pins meet outside the block
`timescale 1ns/1ps
`default_nettype none

module gpa_board (
    input  wire logic [7:0] pad_out_q,
    input  wire logic [7:0] pad_oe_n_q,
    input  wire logic [7:0] ext_val,
    output wire logic [7:0] pad_in
);
    // Driven pins show the device level, released pins the board source
    assign pad_in = (~pad_oe_n_q & pad_out_q) | (pad_oe_n_q & ext_val);
endmodule

`default_nettype wire

// ---- sim/gpa_port_asserts.sv ----
// Checker on the port block pins and bus
`timescale 1ns/1ps
`default_nettype none

module gpa_port_asserts #(
    parameter WIDTH = 8
) (
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic [WIDTH-1:0] pad_in,
    input wire logic [WIDTH-1:0] pad_out_q,
    input wire logic [WIDTH-1:0] pad_oe_n_q,
    input wire logic             timer_ext_clock_in_q,
    input wire logic [WIDTH-1:0] analog_sel_q,
    input wire logic             comparator_ref_out_q,
    input wire logic [1:0]       osc_mode_q
);
    logic       rd_q;
    logic [7:0] ra_q;

    ////////////////////////////////////////////////////////////////////////
    // Read data phase tracking
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            ra_q <= 8'h00;
        end else begin
            rd_q <= hsel && hready && htrans == 2'h2 && !hwrite;
            ra_q <= haddr[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    idle_zero_a: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside read phase");
    analog_low_a: assert property (rd_q && ra_q == 8'h00 |->
        (hrdata[7:0] & analog_sel_q) == 8'h00) else $error("analog pin read high");
    ref_low_a: assert property (rd_q && ra_q == 8'h00 && comparator_ref_out_q
        |-> !hrdata[0]) else $error("reference pin read high");
    osc_zero_a: assert property (rd_q && ra_q <= 8'h08 && osc_mode_q[1]
        |-> hrdata[7:6] == 2'b00) else $error("oscillator pins read high");
    osc_hiz_a: assert property ($past(osc_mode_q[1]) |-> pad_oe_n_q[7:6] == 2'b11)
        else $error("oscillator pins driven");
    clk_out_a: assert property (osc_mode_q == 2'h1 [*4] |-> !pad_oe_n_q[6] &&
        pad_out_q[6] != $past(pad_out_q[6], 2)) else $error("clock out wrong");
    timer_clk_a: assert property ($past(hresetn) |->
        timer_ext_clock_in_q == $past(pad_in[4])) else $error("timer clock wrong");
    rst_vals_a: assert property ($rose(hresetn) |-> analog_sel_q == 8'h2F &&
        pad_oe_n_q == 8'hFF && !comparator_ref_out_q) else $error("reset state wrong");
    an_bits_a: assert property ((analog_sel_q & 8'hD0) == 8'h00)
        else $error("analog select on digital pin");
endmodule

bind gpa_port gpa_port_asserts #(.WIDTH(WIDTH)) i_gpa_port_asserts (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pad_in(pad_in), .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
    .timer_ext_clock_in_q(timer_ext_clock_in_q), .analog_sel_q(analog_sel_q),
    .comparator_ref_out_q(comparator_ref_out_q), .osc_mode_q(osc_mode_q)
);

`default_nettype wire

// ---- sim/bidir_port_a_eight_bit_tb.sv ----
// Self-checking bench for the eight-bit port block
`timescale 1ns/1ps
`default_nettype none
`include "gpa_consts.vh"

module bidir_port_a_eight_bit_tb;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  ext_val = 8'hFF;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire  [7:0]  pad_in;
    wire  [7:0]  pad_out_q;
    wire  [7:0]  pad_oe_n_q;
    wire  [7:0]  asel_q;
    wire         cref_q;
    wire         tclk_q;
    wire  [1:0]  osc_q;
    logic [63:0] expq[$];
    logic [63:0] e;
    logic        rd_ph = 1'b0;
    logic [7:0]  d, l, an, six, own, oe, lvl, pm;
    logic        r;
    logic [1:0]  m;
    int          err_total = 0;
    int          checked = 0;
    int          cyc = 0;
    int          seed = 72580;

    always #12.5 hclk = ~hclk;

    gpa_port #(.WIDTH(8)) i_gpa_port (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pad_in(pad_in),
        .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q), .timer_ext_clock_in_q(tclk_q),
        .analog_sel_q(asel_q), .comparator_ref_out_q(cref_q), .osc_mode_q(osc_q)
    );
    gpa_board i_gpa_board (.pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
        .ext_val(ext_val), .pad_in(pad_in));

    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task cmp_rd(input logic [31:0] exp, input logic [31:0] msk);
        checked++;
        if ((hrdata & msk) !== (exp & msk)) begin
            err_total++;
            $display("ERROR hrdata exp %h seen %h", exp & msk, hrdata & msk);
        end
    endtask

    task cmp_pin(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s exp %h seen %h", nm, exp, got);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        expq.push_back({msk, exp});
        xfer(1'b0, a, 32'h0);
    endtask

    task reset_seq;
        ext_val <= 8'hFF;
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task chk_reset;
        rd(`GPA_OFS_OUTPUT_LATCH, 32'h0, ALL);
        rd(`GPA_OFS_DIRECTION, 32'hFF, ALL);
        rd(`GPA_OFS_ALT_CONFIG, 32'h2F, ALL);
        rd(`GPA_OFS_PIN_LEVELS, 32'hD0, ALL);
        rd(`GPA_OFS_OWNER_STATUS, 32'h2FD0, ALL);
        xfer(1'b1, 8'h14, ALL);
        rd(8'h14, 32'h0, ALL);
        rd(`GPA_OFS_OUTPUT_LATCH, 32'h0, ALL);
        cmp_pin("oe", 8'hFF, pad_oe_n_q);
        $display("test reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read result monitor and hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            stop_test;
        end else begin
            if (rd_ph && hreadyout === 1'b1) begin
                e = expq.pop_front();
                cmp_rd(e[31:0], e[63:32]);
            end
            rd_ph <= hresetn && hsel && htrans == 2'h2 && !hwrite && hreadyout;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_reset;
        for (int i = 0; i < 8; i++) begin
            an = 8'($random(seed));
            r = 1'($random(seed));
            d = 8'($random(seed));
            l = 8'($random(seed));
            m = i[1:0];
            xfer(1'b1, `GPA_OFS_ALT_CONFIG, {21'h0, m, r, an});
            an = an & 8'h2F;
            d = d | an;
            xfer(1'b1, i[0] ? `GPA_OFS_PIN_LEVELS : `GPA_OFS_OUTPUT_LATCH, {24'h0, l});
            xfer(1'b1, `GPA_OFS_DIRECTION, {24'h0, d});
            ext_val <= 8'($random(seed));
            repeat (3) @(posedge hclk);
            six = m[1] ? 8'h3F : (m[0] ? 8'hBF : 8'hFF);
            own = ~an & ~{7'h0, r} & six;
            oe = d | {7'h0, r};
            if (m[1]) oe[7:6] = 2'b11;
            if (m == 2'h1) oe[6] = 1'b0;
            pm = (m == 2'h1) ? 8'hBF : 8'hFF;
            lvl = (~d & l) | (d & ext_val);
            rd(`GPA_OFS_PIN_LEVELS, {24'h0, lvl & own}, ALL);
            rd(`GPA_OFS_OUTPUT_LATCH, {24'h0, l & six}, ALL);
            rd(`GPA_OFS_DIRECTION, {24'h0, d & six}, ALL);
            rd(`GPA_OFS_ALT_CONFIG, {21'h0, m, r, an}, ALL);
            rd(`GPA_OFS_OWNER_STATUS, {8'h0, ~oe, an, own}, ALL);
            cmp_pin("oe", oe, pad_oe_n_q);
            cmp_pin("out", ~oe & l & pm, ~pad_oe_n_q & pad_out_q & pm);
            cmp_pin("asel", an, asel_q);
            cmp_pin("cref", {7'h0, r}, {7'h0, cref_q});
            cmp_pin("osc", {6'h0, m}, {6'h0, osc_q});
            cmp_pin("tclk", {7'h0, lvl[4]}, {7'h0, tclk_q});
        end
        $display("test random pins done");
        reset_seq;
        chk_reset;
        @(posedge hclk);
        if (expq.size() != 0) begin
            err_total++;
            $display("ERROR read queue exp %0d seen %0d", 0, expq.size());
        end
        stop_test;
    end
endmodule

`default_nettype wire
